// ### include/pia_pkg.sv
// Purpose: shared constants and types for the priority interrupt request unit
// Assumes: 16-bit register port, one clock, asynchronous active-low reset
// Notes:   register offsets are word indexes on the plain register port
package pia_pkg;

  localparam int NUM_SRC  = 20;
  localparam int NUM_PAIR = 10;
  localparam int LVL_W    = 3;

  // register offsets (index on the register port)
  localparam logic [4:0]  OFS_LVL_PAIR0 = 5'h00;  // level pairs 0..9 at 0x00..0x09
  localparam logic [4:0]  OFS_VBASE_LO  = 5'h10;
  localparam logic [4:0]  OFS_VBASE_HI  = 5'h11;
  localparam logic [4:0]  OFS_PROT_KEY  = 5'h12;
  localparam logic [4:0]  OFS_STATUS    = 5'h13;

  // field positions
  localparam int LVL_ODD_LSB  = 8;   // source 2x+1
  localparam int LVL_EVEN_LSB = 0;   // source 2x
  localparam int VBL_LSB      = 8;   // writable base bits 15:8
  localparam int VBH_LSB      = 0;   // base bits 23:16
  localparam int STAT_REQ_BIT = 15;
  localparam int STAT_LVL_LSB = 8;
  localparam int STAT_VEC_LSB = 0;

  // reset values and keys
  localparam logic [2:0]  LVL_RST    = 3'h0;
  localparam logic [7:0]  VBL_RST    = 8'h80;
  localparam logic [7:0]  VBH_RST    = 8'h00;
  localparam logic [7:0]  VBL_FIXED  = 8'h00;  // low base byte, always zero
  localparam logic [15:0] KEY_RST    = 16'h0000;
  localparam logic [15:0] KEY_UNLOCK = 16'h0096;
  localparam logic [2:0]  LVL_NONE   = 3'h0;   // level that is never accepted
  localparam logic [4:0]  VEC_FIRST_SRC = 5'h04;  // vector number of source 0

  // peripheral sources in level-field order
  typedef enum logic [4:0] {
    SRC_SUPPLY_DET = 5'h00, SRC_PORT = 5'h01, SRC_POWER_GEN = 5'h02,
    SRC_CLOCK_GEN = 5'h03, SRC_RTC = 5'h04, SRC_TIMER0 = 5'h05,
    SRC_SERIAL0 = 5'h06, SRC_TIMER1 = 5'h07, SRC_SPI0 = 5'h08,
    SRC_I2C = 5'h09, SRC_PWM0 = 5'h0A, SRC_PWM1 = 5'h0B,
    SRC_SERIAL1 = 5'h0C, SRC_TIMER2 = 5'h0D, SRC_SOUND = 5'h0E,
    SRC_DISPLAY = 5'h0F, SRC_RFC0 = 5'h10, SRC_RFC1 = 5'h11,
    SRC_RFC2 = 5'h12, SRC_RFC3 = 5'h13
  } pia_src_t;

  // request toward the processor core
  typedef struct packed {
    logic       req;
    logic [2:0] level;
    logic [4:0] vector;
  } pia_irq_t;

  // register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pia_bus_t;

  typedef logic [NUM_SRC-1:0][LVL_W-1:0] pia_lvl_arr_t;

endpackage : pia_pkg

// ### src/pia_arbiter.sv
// Purpose: picks the pending source with the highest level
// Assumes: candidates already exclude sources taken by the core
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/10ps
`default_nettype none
module pia_arbiter (
  input  wire  pia_pkg::pia_lvl_arr_t i_levels,
  input  wire  logic [19:0]           i_cand,
  output pia_pkg::pia_irq_t           o_best
);
  import pia_pkg::*;

  // scan downward so an equal level at a lower index overrides: lowest vector wins ties
  always_comb begin
    o_best = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (i_cand[i] && i_levels[i] != LVL_NONE &&
          (!o_best.req || i_levels[i] >= o_best.level)) begin
        o_best.req    = 1'b1;
        o_best.level  = i_levels[i];
        o_best.vector = 5'(i) + VEC_FIRST_SRC;
      end
    end
  end

endmodule : pia_arbiter
`default_nettype wire

// ### src/pia_priority_interrupt_accept.sv
// Purpose: level registers, vector base and request forwarding to the core
// Assumes: source lines are levels held until the peripheral flag clears
// Notes:   the core filters on its allow bit and priority floor itself
//
// Overview of operation
// - this unit never raises a non-maskable request
// - base low: bits 15:8 protected, 7:0 zero
// - base high: bits 7:0 protected, upper zero
// - level pair holds fields 10:8, 2:0
// - field equals level, all reset to zero
// - twenty fields serve peripherals in fixed order
// - level zero requests are never forwarded
// - highest level wins, ties to lowest vector
// - vector table always 256-byte aligned
`timescale 1ns/10ps
`default_nettype none
module pia_priority_interrupt_accept (
  input  wire  logic               i_ref_clk,
  input  wire  logic               i_nrst,
  input  wire  pia_pkg::pia_bus_t  i_bus,
  output logic [15:0]              o_rd_data,
  input  wire  logic [19:0]        i_src_req,
  input  wire  logic               i_cpu_ack,
  output pia_pkg::pia_irq_t        o_irq,
  output logic                     o_nmi_req,
  output logic [23:0]              o_vector_base,
  output logic [23:0]              o_vector_addr
);
  import pia_pkg::*;

  pia_lvl_arr_t  lvl_r;
  logic [7:0]    vbl_r;
  logic [7:0]    vbh_r;
  logic [15:0]   key_r;
  logic [19:0]   taken_r;
  logic [19:0]   taken_nxt;
  logic [19:0]   ack_hit;
  logic [19:0]   cand;
  pia_irq_t      best;
  pia_irq_t      irq_r;
  logic [15:0]   rd_data_r;
  logic [15:0]   rd_data_nxt;
  logic          nmi_r;
  logic [23:0]   vbase_r;
  logic [23:0]   vbase_nxt;
  logic [23:0]   vaddr_r;
  logic          unlocked;

  // address decode for one level pair
  function automatic logic f_pair_hit(input logic [4:0] addr, input int p);
    return addr == (OFS_LVL_PAIR0 + 5'(p));
  endfunction : f_pair_hit

  // vector number presented for a source index
  function automatic logic [4:0] f_vec_of(input int i);
    return 5'(i) + VEC_FIRST_SRC;
  endfunction : f_vec_of

  // read image of one level pair, reserved bits zero
  function automatic logic [15:0] f_pair_image(input pia_lvl_arr_t lv, input int p);
    logic [15:0] v;
    v = 16'h0000;
    v[LVL_ODD_LSB +: LVL_W]  = lv[2*p+1];
    v[LVL_EVEN_LSB +: LVL_W] = lv[2*p];
    return v;
  endfunction : f_pair_image

  assign unlocked = (key_r == KEY_UNLOCK);

  // level fields; no protection on these, only on the vector base
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        lvl_r[i] <= LVL_RST;
      end
    end else if (i_bus.wr) begin
      for (int p = 0; p < NUM_PAIR; p++) begin
        if (f_pair_hit(i_bus.addr, p)) begin
          lvl_r[2*p+1] <= i_bus.wdata[LVL_ODD_LSB +: LVL_W];
          lvl_r[2*p]   <= i_bus.wdata[LVL_EVEN_LSB +: LVL_W];
        end
      end
    end
  end

  // protection key; any value but the unlock key relocks
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      key_r <= KEY_RST;
    end else if (i_bus.wr && i_bus.addr == OFS_PROT_KEY) begin
      key_r <= i_bus.wdata;
    end
  end

  // vector base; low byte has no storage at all, so alignment cannot break
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      vbl_r <= VBL_RST;
      vbh_r <= VBH_RST;
    end else if (i_bus.wr && unlocked) begin
      if (i_bus.addr == OFS_VBASE_LO) begin
        vbl_r <= i_bus.wdata[VBL_LSB +: 8];
      end
      if (i_bus.addr == OFS_VBASE_HI) begin
        vbh_r <= i_bus.wdata[VBH_LSB +: 8];
      end
    end
  end

  assign vbase_nxt = {vbh_r, vbl_r, VBL_FIXED};

  // read mux; data stand only in the cycle after the strobe
  always_comb begin
    rd_data_nxt = 16'h0000;
    if (i_bus.rd) begin
      for (int p = 0; p < NUM_PAIR; p++) begin
        if (f_pair_hit(i_bus.addr, p)) begin
          rd_data_nxt = f_pair_image(lvl_r, p);
        end
      end
      case (i_bus.addr)
        OFS_VBASE_LO: rd_data_nxt = {vbl_r, VBL_FIXED};
        OFS_VBASE_HI: rd_data_nxt = {8'h00, vbh_r};
        OFS_PROT_KEY: rd_data_nxt = key_r;
        OFS_STATUS: begin
          rd_data_nxt[STAT_REQ_BIT]         = irq_r.req;
          rd_data_nxt[STAT_LVL_LSB +: 3]    = irq_r.level;
          rd_data_nxt[STAT_VEC_LSB +: 5]    = irq_r.vector;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_data_r <= 16'h0000;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // a source taken by the core stays out until its line drops,
  // so the next lower request is presented instead; the take wins over the clear
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      ack_hit[i] = i_cpu_ack && irq_r.req && irq_r.vector == f_vec_of(i);
    end
    taken_nxt = ack_hit | (taken_r & i_src_req);
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      taken_r <= 20'h00000;
    end else begin
      taken_r <= taken_nxt;
    end
  end

  assign cand = i_src_req & ~taken_r & ~ack_hit;

  pia_arbiter u_arb (
    .i_levels (lvl_r),
    .i_cand   (cand),
    .o_best   (best)
  );

  // request, level and vector move together; a newer higher request replaces the old
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_r <= '0;
    end else begin
      irq_r <= best;
    end
  end

  // no source may raise a non-maskable request
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      nmi_r <= 1'b0;
    end else begin
      nmi_r <= 1'b0;
    end
  end

  // base and fetch address, ready for the core's vector load
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      vbase_r <= {VBH_RST, VBL_RST, VBL_FIXED};
      vaddr_r <= {VBH_RST, VBL_RST, VBL_FIXED};
    end else begin
      vbase_r <= vbase_nxt;
      vaddr_r <= vbase_nxt + {17'h00000, best.vector, 2'b00};
    end
  end

  assign o_rd_data     = rd_data_r;
  assign o_irq         = irq_r;
  assign o_nmi_req     = nmi_r;
  assign o_vector_base = vbase_r;
  assign o_vector_addr = vaddr_r;

  // checking helper: no candidate beats the arbiter's pick
  logic arb_ok;
  always_comb begin
    arb_ok = 1'b1;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (cand[i] && lvl_r[i] != LVL_NONE) begin
        if (!best.req || lvl_r[i] > best.level ||
            (lvl_r[i] == best.level && f_vec_of(i) < best.vector)) begin
          arb_ok = 1'b0;
        end
      end
    end
  end

  property p_no_nmi;
    @(posedge i_ref_clk) disable iff (!i_nrst) o_nmi_req == 1'b0;
  endproperty
  a_no_nmi: assert property (p_no_nmi) else $error("nmi raised");

  property p_base_locked;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (i_bus.wr && i_bus.addr == OFS_VBASE_LO && !unlocked) |=> $stable(vbl_r);
  endproperty
  a_base_locked: assert property (p_base_locked) else $error("locked base changed");

  property p_hi_read;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (i_bus.rd && i_bus.addr == OFS_VBASE_HI) |=> (o_rd_data == {8'h00, $past(vbh_r)});
  endproperty
  a_hi_read: assert property (p_hi_read) else $error("base high read wrong");

  property p_pair_rsvd;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (i_bus.rd && i_bus.addr < 5'h0A) |=> (o_rd_data[15:11] == 5'h00 && o_rd_data[7:3] == 5'h00);
  endproperty
  a_pair_rsvd: assert property (p_pair_rsvd) else $error("level reserved bits set");

  property p_pair_write;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (i_bus.wr && i_bus.addr == 5'h00) |=> (lvl_r[1] == $past(i_bus.wdata[10:8]) &&
                                             lvl_r[0] == $past(i_bus.wdata[2:0]));
  endproperty
  a_pair_write: assert property (p_pair_write) else $error("level write lost");

  property p_no_level0;
    @(posedge i_ref_clk) disable iff (!i_nrst) o_irq.req |-> o_irq.level != LVL_NONE;
  endproperty
  a_no_level0: assert property (p_no_level0) else $error("level zero forwarded");

  property p_arb_pick;
    @(posedge i_ref_clk) disable iff (!i_nrst) arb_ok ##1 o_irq == $past(best);
  endproperty
  a_arb_pick: assert property (p_arb_pick) else $error("wrong request chosen");

  property p_aligned;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      o_vector_base[7:0] == 8'h00 && o_vector_addr[1:0] == 2'b00;
  endproperty
  a_aligned: assert property (p_aligned) else $error("vector table misaligned");

  property p_hi_locked;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (i_bus.wr && i_bus.addr == OFS_VBASE_HI && !unlocked) |=> $stable(vbh_r);
  endproperty
  a_hi_locked: assert property (p_hi_locked) else $error("locked base high changed");

  property p_lo_read;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (i_bus.rd && i_bus.addr == OFS_VBASE_LO) |=> (o_rd_data == {$past(vbl_r), VBL_FIXED});
  endproperty
  a_lo_read: assert property (p_lo_read) else $error("base low read wrong");

  property p_vaddr;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      o_irq.req |-> (o_vector_addr == o_vector_base + {17'h00000, o_irq.vector, 2'b00});
  endproperty
  a_vaddr: assert property (p_vaddr) else $error("fetch address wrong");

  property p_take_excl;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (i_cpu_ack && o_irq.req) |=> !(o_irq.req && o_irq.vector == $past(o_irq.vector));
  endproperty
  a_take_excl: assert property (p_take_excl) else $error("taken request presented again");

  property p_key_relock;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (i_bus.wr && i_bus.addr == OFS_PROT_KEY && i_bus.wdata != KEY_UNLOCK) |=> !unlocked;
  endproperty
  a_key_relock: assert property (p_key_relock) else $error("protection not restored");

endmodule : pia_priority_interrupt_accept
`default_nettype wire

// ### sim/pia_core_model.sv
// Purpose: behavioural processor core facing the request unit
// Assumes: acceptance is combinational, state updates on the accept edge, or one edge later when woken from a halt
// Notes:   one save slot only, so nesting deeper than one level is not modelled
`timescale 1ns/10ps
`default_nettype none
module pia_core_model (
  input  wire  logic              i_ref_clk,
  input  wire  logic              i_nrst,
  input  wire  pia_pkg::pia_irq_t i_irq,
  input  wire  logic              i_nmi,
  input  wire  logic              i_allow_set,
  input  wire  logic              i_floor_ld,
  input  wire  logic [2:0]        i_floor_val,
  input  wire  logic              i_trap,
  input  wire  logic [4:0]        i_trap_vec,
  input  wire  logic              i_ret,
  input  wire  logic              i_halt,
  output logic                    o_ack,
  output logic                    o_allow,
  output logic [2:0]              o_floor,
  output logic [4:0]              o_taken
);
  import pia_pkg::*;
  logic       save_allow_r;
  logic [2:0] save_floor_r;
  logic       halt_r;
  logic       wake_r;
  logic [2:0] wake_lvl_r;
  logic [4:0] wake_vec_r;
  // accept only when allowed, above the floor and nothing higher waits; not again while waking
  assign o_ack = i_irq.req && o_allow && (i_irq.level > o_floor) && !i_nmi && !wake_r;
  // entry wins over a software request in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_allow      <= 1'b0;
      o_floor      <= 3'h0;
      o_taken      <= 5'h00;
      save_allow_r <= 1'b0;
      save_floor_r <= 3'h0;
      halt_r       <= 1'b0;
      wake_r       <= 1'b0;
      wake_lvl_r   <= 3'h0;
      wake_vec_r   <= 5'h00;
    end else if (wake_r) begin
      // the instruction after the halt has run, so enter now
      save_allow_r <= o_allow;
      save_floor_r <= o_floor;
      o_allow      <= 1'b0;
      o_floor      <= wake_lvl_r;
      o_taken      <= wake_vec_r;
      wake_r       <= 1'b0;
    end else if (o_ack && halt_r) begin
      halt_r     <= 1'b0;
      wake_r     <= 1'b1;
      wake_lvl_r <= i_irq.level;
      wake_vec_r <= i_irq.vector;
    end else if (o_ack || i_trap) begin
      save_allow_r <= o_allow;
      save_floor_r <= o_floor;
      o_allow      <= 1'b0;
      if (o_ack) begin
        o_floor <= i_irq.level;
        o_taken <= i_irq.vector;
      end else begin
        o_taken <= i_trap_vec;
        if (i_floor_ld) begin
          o_floor <= i_floor_val;
        end
      end
    end else if (i_ret) begin
      o_allow <= save_allow_r;
      o_floor <= save_floor_r;
    end else begin
      if (i_allow_set) o_allow <= 1'b1;
      if (i_floor_ld) o_floor <= i_floor_val;
      if (i_halt) halt_r <= 1'b1;
    end
  end
endmodule : pia_core_model
`default_nettype wire

// ### sim/tb_pia_priority_interrupt_accept.sv
// Purpose: self-checking bench for the priority interrupt request unit
// Assumes: reads are judged in the cycle after the read strobe
// Notes:   core model drives the acknowledge, bench steers its allow bit
`timescale 1ns/10ps
`default_nettype none
module tb_pia_priority_interrupt_accept;
  import pia_pkg::*;
  logic        i_ref_clk;
  logic        i_nrst;
  pia_bus_t    bus;
  logic [15:0] rd_data;
  logic [19:0] src_req;
  logic        ack;
  pia_irq_t    irq;
  logic        nmi;
  logic [23:0] vbase;
  logic [23:0] vaddr;
  logic        allow_set;
  logic        floor_ld;
  logic [2:0]  floor_val;
  logic        allow;
  logic [2:0]  floor;
  logic [4:0]  taken;
  logic        trap;
  logic [4:0]  trap_vec;
  logic        ret;
  logic        halt;
  logic [15:0] d;
  int          err_count;
  int          checked;

  pia_priority_interrupt_accept pia_priority_interrupt_accept_inst (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_bus(bus), .o_rd_data(rd_data),
    .i_src_req(src_req), .i_cpu_ack(ack), .o_irq(irq), .o_nmi_req(nmi),
    .o_vector_base(vbase), .o_vector_addr(vaddr));
  pia_core_model pia_core_model_inst (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_irq(irq), .i_nmi(nmi),
    .i_allow_set(allow_set), .i_floor_ld(floor_ld), .i_floor_val(floor_val),
    .i_trap(trap), .i_trap_vec(trap_vec), .i_ret(ret), .i_halt(halt),
    .o_ack(ack), .o_allow(allow), .o_floor(floor), .o_taken(taken));

  // free-running 250 MHz clock
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  // one-cycle strobes; a gap cycle follows so no signal is set twice at once
  task automatic bus_wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge i_ref_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge i_ref_clk);
    bus <= '0;
  endtask : bus_wr

  task automatic bus_rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge i_ref_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge i_ref_clk);
    bus <= '0;
    #1 v = rd_data;
  endtask : bus_rd

  task automatic core_pulse(input logic a, input logic f, input logic [2:0] v);
    @(posedge i_ref_clk);
    allow_set <= a;
    floor_ld  <= f;
    floor_val <= v;
    @(posedge i_ref_clk);
    allow_set <= 1'b0;
    floor_ld  <= 1'b0;
  endtask : core_pulse

  // one-cycle trap, return or halt; returns once the core state has settled
  task automatic core_op(input logic t, input logic r, input logic h, input logic [4:0] v);
    @(posedge i_ref_clk);
    trap     <= t;
    ret      <= r;
    halt     <= h;
    trap_vec <= v;
    @(posedge i_ref_clk);
    trap <= 1'b0;
    ret  <= 1'b0;
    halt <= 1'b0;
    #1;
  endtask : core_op

  // bounded wait for the core to enter a handler
  task automatic wait_entry;
    int n;
    n = 0;
    #1;
    while (allow === 1'b1 && n < 20) begin
      @(posedge i_ref_clk);
      #1 n++;
    end
    if (n == 20) begin
      err_count++;
      close_out();
    end
  endtask : wait_entry

  task automatic settle;
    repeat (2) @(posedge i_ref_clk);
    #1;
  endtask : settle

  task automatic t_reset;
    for (int x = 0; x < NUM_PAIR; x++) begin
      bus_rd(OFS_LVL_PAIR0 + 5'(x), d);
      check(d, 16'h0000);
    end
    bus_rd(OFS_VBASE_LO, d);
    check(d, 16'h8000);
    bus_rd(OFS_VBASE_HI, d);
    check(d, 16'h0000);
    check(vbase, 24'h008000);
    check(vaddr, 24'h008000);
    check(nmi, 1'b0);
  endtask : t_reset

  task automatic t_regs;
    bus_wr(OFS_LVL_PAIR0 + 5'h03, 16'hFFFF);
    bus_rd(OFS_LVL_PAIR0 + 5'h03, d);
    check(d, 16'h0707);
    bus_wr(OFS_LVL_PAIR0 + 5'h03, 16'h0000);
    bus_wr(OFS_VBASE_LO, 16'h12FF);
    bus_rd(OFS_VBASE_LO, d);
    check(d, 16'h8000);
    bus_wr(OFS_PROT_KEY, KEY_UNLOCK);
    bus_wr(OFS_VBASE_LO, 16'h12FF);
    bus_wr(OFS_VBASE_HI, 16'hFFAB);
    bus_wr(OFS_PROT_KEY, 16'h0001);
    bus_wr(OFS_VBASE_LO, 16'h3400);
    bus_wr(OFS_VBASE_HI, 16'h0055);
    bus_rd(OFS_PROT_KEY, d);
    check(d, 16'h0001);
    bus_rd(OFS_VBASE_LO, d);
    check(d, 16'h1200);
    bus_rd(OFS_VBASE_HI, d);
    check(d, 16'h00AB);
    @(posedge i_ref_clk);
    #1 check(rd_data, 16'h0000);
    check(vbase, 24'hAB1200);
    bus_rd(5'h1F, d);
    check(d, 16'h0000);
  endtask : t_regs

  // each field alone at level 1 gives its own vector and fetch address
  task automatic t_map;
    for (int i = 0; i < NUM_SRC; i++) begin
      bus_wr(OFS_LVL_PAIR0 + 5'(i / 2), (i % 2) ? 16'h0100 : 16'h0001);
      @(posedge i_ref_clk);
      src_req <= 20'h00001 << i;
      settle();
      check({irq.req, irq.level, irq.vector}, {1'b1, 3'h1, 5'(i + 4)});
      check(vaddr, 24'hAB1200 + 24'(4 * (i + 4)));
      bus_wr(OFS_LVL_PAIR0 + 5'(i / 2), 16'h0000);
      src_req <= 20'h00000;
    end
  endtask : t_map

  task automatic t_arb;
    @(posedge i_ref_clk);
    src_req <= 20'h00284;
    settle();
    check(irq.req, 1'b0);
    bus_wr(OFS_LVL_PAIR0 + 5'h01, 16'h0003);
    bus_wr(OFS_LVL_PAIR0 + 5'h03, 16'h0500);
    bus_wr(OFS_LVL_PAIR0 + 5'h04, 16'h0500);
    settle();
    check({irq.req, irq.level, irq.vector}, {1'b1, 3'h5, 5'h0B});
    bus_rd(OFS_STATUS, d);
    check(d, 16'h850B);
    core_pulse(1'b1, 1'b0, 3'h0);
    wait_entry();
    check({taken, floor}, {5'h0B, 3'h5});
    settle();
    check({irq.req, irq.level, irq.vector}, {1'b1, 3'h5, 5'h0D});
    core_pulse(1'b1, 1'b0, 3'h0);
    settle();
    check({allow, taken}, {1'b1, 5'h0B});
    core_pulse(1'b0, 1'b1, 3'h0);
    wait_entry();
    check(taken, 5'h0D);
    settle();
    check({irq.req, irq.level, irq.vector}, {1'b1, 3'h3, 5'h06});
    @(posedge i_ref_clk);
    src_req <= 20'h00000;
    settle();
    check(irq.req, 1'b0);
    check(nmi, 1'b0);
  endtask : t_arb

  // return, unmaskable traps, and the extra instruction after a halt wake
  task automatic t_trap;
    core_op(1'b0, 1'b1, 1'b0, 5'h00);
    check({allow, floor}, {1'b1, 3'h0});
    core_pulse(1'b0, 1'b1, 3'h7);
    core_op(1'b1, 1'b0, 1'b0, 5'h1F);
    check({allow, taken, floor}, {1'b0, 5'h1F, 3'h7});
    core_op(1'b1, 1'b0, 1'b0, 5'h00);
    check(taken, 5'h00);
    core_pulse(1'b1, 1'b1, 3'h0);
    core_op(1'b0, 1'b0, 1'b1, 5'h00);
    @(posedge i_ref_clk);
    src_req <= 20'h00004;
    settle();
    check({allow, taken, irq.req}, {1'b1, 5'h00, 1'b0});
    @(posedge i_ref_clk);
    #1 check({allow, taken, floor}, {1'b0, 5'h06, 3'h3});
    @(posedge i_ref_clk);
    src_req <= 20'h00000;
  endtask : t_trap

  initial begin
    err_count = 0;
    checked   = 0;
    i_nrst    = 1'b0;
    bus       = '0;
    src_req   = 20'h00000;
    allow_set = 1'b0;
    floor_ld  = 1'b0;
    floor_val = 3'h0;
    trap      = 1'b0;
    trap_vec  = 5'h00;
    ret       = 1'b0;
    halt      = 1'b0;
    repeat (3) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    t_reset();
    t_regs();
    t_map();
    t_arb();
    t_trap();
    close_out();
  end
endmodule : tb_pia_priority_interrupt_accept
`default_nettype wire
